// *** apd_params.svh ***
// Constants for the angle PLL direction and sync-count block.
// Assumes inclusion by the package and the top design file by bare name.
`ifndef APD_PARAMS_SVH
`define APD_PARAMS_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define APD_OFF_CTRL 12'h000
`define APD_OFF_STATUS 12'h004
`define APD_OFF_THRESH 12'h008
`define APD_OFF_NUTC 12'h00C
`define APD_OFF_NUSC 12'h010
// ------------------------------------------------------------
// Field positions and sync field width
// ------------------------------------------------------------
`define APD_CTRL_EN_BIT 0
`define APD_CTRL_DDS_BIT 1
`define APD_STAT_BWD_BIT 0
`define APD_STAT_IBWD_BIT 1
`define APD_NU_SYN_LSB 0
`define APD_NU_OLD_LSB 10
`define APD_NU_WRITE_SYNC_ENABLE_BIT 31
`define APD_SYN_W 10
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define APD_CTRL_RST 32'h0000_0000
`define APD_THRESH_RST 16'h0000
`define APD_BWD_RST 1'b0
`endif

// *** apd_pkg.sv ***
// Types shared by the angle PLL direction block.
// Assumes the params header sits in the same folder.
`include "apd_params.svh"
package apd_pkg;
  typedef enum logic [1:0] {APD_IDLE, APD_HIGH} apd_trg_state_t;
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } apd_req_t;
endpackage

// *** apd_pulse_meas.sv ***
// Trigger pulse width measurement for the angle PLL.
// Assumes trigger input is synchronous to pclk, active high.
`timescale 1ns/100ps
`default_nettype none
module apd_pulse_meas #(
  parameter int CW = 16
) (
  input wire logic pclk, // Module clock
  input wire logic presetn, // Async reset, active low
  input wire logic trig, // Trigger input level
  input wire logic [CW-1:0] thresh, // Pulse width threshold
  output logic inact_edge, // Inactive edge pulse
  output logic short_pulse // Last pulse within threshold
);
  typedef struct packed {
    apd_pkg::apd_trg_state_t st;
    logic [CW-1:0] cnt;
    logic prev;
  } apd_meas_t;
  apd_meas_t s_q, s_d;
  // ------------------------------------------------------------
  // Edge detect and width counter
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.prev = trig;
    case (s_q.st)
      apd_pkg::APD_IDLE:
        if (trig && !s_q.prev)
        begin
          s_d.st = apd_pkg::APD_HIGH;
          s_d.cnt = '0;
        end
      apd_pkg::APD_HIGH:
        if (!trig)
          s_d.st = apd_pkg::APD_IDLE;
        else if (s_q.cnt != '1)
          s_d.cnt = s_q.cnt + 1'b1; // Saturate so long pulses stay long
      default: s_d.st = apd_pkg::APD_IDLE;
    endcase
  end
  assign inact_edge = (s_q.st == apd_pkg::APD_HIGH) && !trig;
  assign short_pulse = s_q.cnt <= thresh;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '{st: apd_pkg::APD_IDLE, cnt: '0, prev: 1'b0};
    else
      s_q <= s_d;
  end
endmodule
`default_nettype wire

// *** apd_angle_pll_dir.sv ***
// Angle PLL direction tracking and sync-count registers, APB slave.
// Assumes APB master in pclk domain; trigger and pins are synchronous.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "apd_params.svh"
module apd_angle_pll_dir #(
  parameter int THW = 16
) (
  input wire logic pclk, // Module clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic trigger_in, // Trigger input from sensor
  input wire logic direction_input_pin, // Dedicated direction pin
  output logic backward_dir_flag // Readable direction status
);
  typedef struct packed {
    logic en;
    logic dds;
    logic [THW-1:0] thr;
    logic int_bwd;
    logic [`APD_SYN_W-1:0] syn_t;
    logic [`APD_SYN_W-1:0] old_t;
    logic [`APD_SYN_W-1:0] syn_s;
    logic [`APD_SYN_W-1:0] old_s;
    logic write_sync_enable_t;
    logic write_sync_enable_s;
    logic [31:0] rdata;
  } apd_state_t;
  apd_state_t s_q, s_d;
  apd_pkg::apd_req_t req;
  logic inact_edge;
  logic short_pulse;
  logic acc;
  logic mapped;

  // ------------------------------------------------------------
  // Trigger pulse measurement
  // ------------------------------------------------------------
  apd_pulse_meas #(.CW(THW)) u_meas (
    .pclk(pclk),
    .presetn(presetn),
    .trig(trigger_in),
    .thresh(s_q.thr),
    .inact_edge(inact_edge),
    .short_pulse(short_pulse)
  );

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `APD_OFF_CTRL) || (a == `APD_OFF_STATUS) ||
      (a == `APD_OFF_THRESH) || (a == `APD_OFF_NUTC) || (a == `APD_OFF_NUSC);
  endfunction

  // Bus request bundle; zero-wait slave
  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign acc = psel && penable;
  assign mapped = is_mapped(req.addr);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = s_q.rdata;
  // Status masked while disabled, internal direction kept
  assign backward_dir_flag = s_q.en ? s_q.int_bwd : `APD_BWD_RST;

  // ------------------------------------------------------------
  // Next state: registers and direction
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Direction only moves while enabled; disable never clears it
    if (s_q.en)
    begin
      if (s_q.dds)
        s_d.int_bwd = direction_input_pin;
      else if (inact_edge)
        s_d.int_bwd = !short_pulse;
    end
    // Read data captured in setup so it stands in the access phase
    if (psel && !penable && !req.write)
    begin
      case (req.addr)
        `APD_OFF_CTRL: s_d.rdata = {30'h0, s_q.dds, s_q.en};
        `APD_OFF_STATUS: s_d.rdata = {30'h0, s_q.int_bwd, backward_dir_flag};
        `APD_OFF_THRESH: s_d.rdata = 32'(s_q.thr);
        `APD_OFF_NUTC: s_d.rdata = {s_q.write_sync_enable_t, 11'h000, s_q.old_t, s_q.syn_t};
        `APD_OFF_NUSC: s_d.rdata = {s_q.write_sync_enable_s, 11'h000, s_q.old_s, s_q.syn_s};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (acc && req.write)
    begin
      case (req.addr)
        `APD_OFF_CTRL:
        begin
          s_d.en = req.wdata[`APD_CTRL_EN_BIT];
          s_d.dds = req.wdata[`APD_CTRL_DDS_BIT];
        end
        `APD_OFF_THRESH: s_d.thr = req.wdata[THW-1:0];
        `APD_OFF_NUTC:
        begin
          s_d.write_sync_enable_t = req.wdata[`APD_NU_WRITE_SYNC_ENABLE_BIT];
          // Old field takes written bits, not the previous sync value
          if (req.wdata[`APD_NU_WRITE_SYNC_ENABLE_BIT])
          begin
            s_d.syn_t = req.wdata[`APD_NU_SYN_LSB +: `APD_SYN_W];
            s_d.old_t = req.wdata[`APD_NU_OLD_LSB +: `APD_SYN_W];
          end
        end
        `APD_OFF_NUSC:
        begin
          s_d.write_sync_enable_s = req.wdata[`APD_NU_WRITE_SYNC_ENABLE_BIT];
          if (req.wdata[`APD_NU_WRITE_SYNC_ENABLE_BIT])
          begin
            s_d.syn_s = req.wdata[`APD_NU_SYN_LSB +: `APD_SYN_W];
            s_d.old_s = req.wdata[`APD_NU_OLD_LSB +: `APD_SYN_W];
          end
        end
        default: s_d.en = s_q.en;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.thr <= `APD_THRESH_RST;
    end
    else
      s_q <= s_d;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_dis_masks;
    @(posedge pclk) disable iff (!presetn)
      !s_q.en |-> !backward_dir_flag;
  endproperty
  a_dis_masks: assert property (p_dis_masks) else $error("status not reset value while off");
  property p_dis_keeps;
    @(posedge pclk) disable iff (!presetn)
      !s_q.en |=> s_q.int_bwd == $past(s_q.int_bwd);
  endproperty
  a_dis_keeps: assert property (p_dis_keeps) else $error("internal dir changed while off");
  property p_reen;
    @(posedge pclk) disable iff (!presetn)
      $rose(s_q.en) |-> backward_dir_flag == s_q.int_bwd;
  endproperty
  a_reen: assert property (p_reen) else $error("status not restored on enable");
  property p_fwd;
    @(posedge pclk) disable iff (!presetn)
      s_q.en && !s_q.dds && inact_edge && short_pulse |=> !backward_dir_flag;
  endproperty
  a_fwd: assert property (p_fwd) else $error("short pulse did not give forward");
  property p_pin;
    @(posedge pclk) disable iff (!presetn)
      s_q.en && s_q.dds |=> s_q.int_bwd == $past(direction_input_pin);
  endproperty
  a_pin: assert property (p_pin) else $error("pin direction not followed");
  property p_long;
    @(posedge pclk) disable iff (!presetn)
      s_q.en && !s_q.dds && inact_edge && !short_pulse |=> s_q.int_bwd;
  endproperty
  a_long: assert property (p_long) else $error("long pulse did not give backward");
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      s_q.en && !s_q.dds && !inact_edge |=> s_q.int_bwd == $past(s_q.int_bwd);
  endproperty
  a_hold: assert property (p_hold) else $error("direction moved without edge");
  property p_syn;
    @(posedge pclk) disable iff (!presetn)
      acc && req.write && req.addr == `APD_OFF_NUTC && req.wdata[31]
      |=> s_q.old_t == $past(req.wdata[19:10]) && s_q.syn_t == $past(req.wdata[9:0]);
  endproperty
  a_syn: assert property (p_syn) else $error("sync fields not from write data");
  // Status read path: bit 1 internal direction, bit 0 masked flag
  property p_stat;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == `APD_OFF_STATUS
      |=> s_q.rdata[1:0] == {$past(s_q.int_bwd), $past(s_q.en) && $past(s_q.int_bwd)};
  endproperty
  a_stat: assert property (p_stat) else $error("status differs from direction");
  c_toggle: cover property (@(posedge pclk) disable iff (!presetn) $fell(s_q.en) ##[1:20] s_q.en);
  c_short: cover property (@(posedge pclk) disable iff (!presetn) inact_edge && short_pulse);
  c_pin: cover property (@(posedge pclk) disable iff (!presetn) s_q.dds && $rose(s_q.int_bwd));
endmodule
`default_nettype wire

// *** apd_sensor_model.sv ***
// Sensor side model: trigger pulses and the dedicated direction pin.
// Assumes pclk from the bench; levels change just after rising edges.
`timescale 1ns/100ps
`default_nettype none
module apd_sensor_model (
  input wire logic pclk, // Module clock
  output logic trigger_in, // Trigger level to block
  output logic direction_input_pin // Direction pin level
);
  // ----------------------------------------------------------
  // Idle levels and drive tasks
  // ----------------------------------------------------------
  // Both lines idle low, which is also forward on the pin
  initial
  begin
    trigger_in = 1'b0;
    direction_input_pin = 1'b0;
  end
  // Active edge, w high cycles, inactive edge, then a low gap
  task automatic pulse(input int w);
    @(posedge pclk);
    trigger_in <= 1'b1;
    repeat (w) @(posedge pclk);
    trigger_in <= 1'b0;
    // Gap long enough for the one-cycle evaluation to land
    repeat (3) @(posedge pclk);
  endtask
  // Pin level as the integrating logic would set it
  task automatic set_pin(input logic v);
    @(posedge pclk);
    direction_input_pin <= v;
    repeat (3) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// *** apd_angle_pll_dir_tb.sv ***
// Bench for the angle PLL direction block: APB tasks and sequences.
// Assumes the sensor model drives trigger and pin; one pclk domain.
`timescale 1ns/100ps
`default_nettype none
`include "apd_params.svh"
module apd_angle_pll_dir_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trigger_in;
  logic direction_input_pin;
  logic backward_dir_flag;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int samples_checked = 0;
  // ----------------------------------------------------------
  // Clock, design and sensor
  // ----------------------------------------------------------
  // 200 MHz module clock
  always #2.5 pclk = ~pclk;
  apd_angle_pll_dir #(.THW(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
    .direction_input_pin(direction_input_pin), .backward_dir_flag(backward_dir_flag));
  apd_sensor_model sensor (.pclk(pclk), .trigger_in(trigger_in),
    .direction_input_pin(direction_input_pin));
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits on pready, no cycle count assumed
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Flag is combinational, so look at it mid-cycle
  task automatic chk_flag(input logic exp);
    @(negedge pclk);
    chk({31'h0, backward_dir_flag}, {31'h0, exp});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog, far beyond the hundred-odd cycles the tests need
  initial
  begin
    #20000;
    miscompares++;
    test_done;
  end
  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial
  begin
    logic [11:0] a;
    // Bus idle while reset is held
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(`APD_OFF_CTRL, 1'b0, 32'h0);
    chk(rd, `APD_CTRL_RST);
    chk({31'h0, err}, 32'h0);
    apb(`APD_OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    // Threshold 4: widths 6 and 5 straddle the inclusive limit
    apb(`APD_OFF_THRESH, 1'b1, 32'h4);
    apb(`APD_OFF_CTRL, 1'b1, 32'h1);
    apb(`APD_OFF_THRESH, 1'b0, 32'h0);
    chk(rd, 32'h4);
    apb(`APD_OFF_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h1);
    sensor.pulse(6);
    chk_flag(1'b1);
    sensor.pulse(5);
    chk_flag(1'b0);
    sensor.pulse(7);
    chk_flag(1'b1);
    apb(`APD_OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h3);
    // Disable: flag masked, internal direction kept, pulses ignored
    apb(`APD_OFF_CTRL, 1'b1, 32'h0);
    chk_flag(1'b0);
    sensor.pulse(1);
    apb(`APD_OFF_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h2);
    apb(`APD_OFF_CTRL, 1'b1, 32'h1);
    chk_flag(1'b1);
    sensor.pulse(1);
    chk_flag(1'b0);
    $display("test trigger done");
    // Pin mode: high is backward, low is forward
    apb(`APD_OFF_CTRL, 1'b1, 32'h3);
    sensor.set_pin(1'b1);
    chk_flag(1'b1);
    sensor.set_pin(1'b0);
    chk_flag(1'b0);
    $display("test pin done");
    // Both tick-count registers: direct load, then read-modify-write
    for (int i = 0; i < 2; i++)
    begin
      a = (i == 0) ? `APD_OFF_NUTC : `APD_OFF_NUSC;
      apb(a, 1'b1, 32'h800A_A955);
      apb(a, 1'b0, 32'h0);
      chk(rd, 32'h800A_A955);
      apb(a, 1'b1, {1'b1, 11'h0, rd[9:0], 10'h0F0});
      apb(a, 1'b0, 32'h0);
      chk(rd, 32'h8005_54F0);
      apb(a, 1'b1, 32'h0000_0123);
      apb(a, 1'b0, 32'h0);
      chk(rd, 32'h0005_54F0);
    end
    $display("test sync done");
    // Unmapped address: error, nothing stored, reads zero
    apb(12'hFFC, 1'b1, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    apb(12'hFFC, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("test unmapped done");
    test_done;
  end
endmodule
`default_nettype wire
